// >>> cis_pkg.sv
/*
 * Constants and helpers of the CPU interrupt selector.
 * Assumes a 32-bit Avalon-MM slave port with byte addresses.
 */
package cis_pkg;

    // ****************************************************************
    // register map (byte addresses, word aligned)
    // ****************************************************************
    localparam int          CIS_AW            = 32;
    localparam logic [31:0] CIS_ROUTE_HIGH    = 32'h019c_0000;
    localparam logic [31:0] CIS_ROUTE_LOW     = 32'h019c_0004;
    localparam logic [31:0] CIS_EXT_POLARITY  = 32'h019c_0008;
    localparam logic [31:0] CIS_IRQ_STATUS    = 32'h019c_0010;
    localparam logic [31:0] CIS_IRQ_CLEAR     = 32'h019c_0014;
    localparam logic [31:0] CIS_IRQ_ENABLE    = 32'h019c_0018;
    localparam logic [31:0] CIS_ROUTE_OUT     = 32'h019c_001c;
    localparam logic [31:0] CIS_UNMAPPED_DATA = 32'h0000_0000;

    // ****************************************************************
    // selector fields
    // ****************************************************************
    localparam int          CIS_SEL_W      = 5;
    localparam int          CIS_FIELDS     = 6;
    localparam int          CIS_NUM_INT    = 16;
    localparam int          CIS_FIRST_MASK = 4;
    localparam int          CIS_NUM_SRC    = 32;
    localparam int          CIS_NUM_EXT    = 4;
    localparam int          CIS_EXT_FIRST  = 4;
    // low bit of each field; bits 15 and 31 belong to none
    localparam int          CIS_FIELD_LSB [CIS_FIELDS] = '{0, 5, 10, 16, 21, 26};
    localparam logic [31:0] CIS_ROUTE_MASK = 32'h7fff_7fff;
    localparam logic [31:0] CIS_POL_MASK   = 32'h0000_000f;

    // ****************************************************************
    // reset routing
    // ****************************************************************
    localparam logic [31:0] CIS_ROUTE_LOW_RST  = {1'b0, 5'h09, 5'h08, 5'h07, 1'b0, 5'h06, 5'h05, 5'h04};
    localparam logic [31:0] CIS_ROUTE_HIGH_RST = {1'b0, 5'h02, 5'h01, 5'h00, 1'b0, 5'h0b, 5'h0a, 5'h03};
    localparam logic [31:0] CIS_POL_RST        = 32'h0000_0000;

    // ****************************************************************
    // source codes
    // ****************************************************************
    localparam logic [4:0] CIS_SRC_HOST_PORT   = 5'h00;
    localparam logic [4:0] CIS_SRC_TIMER0      = 5'h01;
    localparam logic [4:0] CIS_SRC_TIMER1      = 5'h02;
    localparam logic [4:0] CIS_SRC_REFRESH     = 5'h03;
    localparam logic [4:0] CIS_SRC_PIN4        = 5'h04;
    localparam logic [4:0] CIS_SRC_DMA         = 5'h08;
    localparam logic [4:0] CIS_SRC_DBG_DMA     = 5'h09;
    localparam logic [4:0] CIS_SRC_DBG_RX      = 5'h0a;
    localparam logic [4:0] CIS_SRC_DBG_TX      = 5'h0b;
    localparam logic [4:0] CIS_SRC_SSP_TX      = 5'h0c;
    localparam logic [4:0] CIS_SRC_SSP_RX      = 5'h0d;
    localparam logic [4:0] CIS_SRC_GPIO0       = 5'h10;
    localparam logic [4:0] CIS_SRC_TIMER2      = 5'h13;
    localparam logic [4:0] CIS_SRC_TWO_WIRE    = 5'h16;
    localparam logic [4:0] CIS_SRC_NET_MGMT    = 5'h18;
    localparam logic [4:0] CIS_SRC_VIDEO1      = 5'h1a;
    localparam logic [4:0] CIS_SRC_VIDEO2      = 5'h1b;
    localparam logic [4:0] CIS_SRC_AUDIO_TX    = 5'h1c;
    localparam logic [4:0] CIS_SRC_AUDIO_RX    = 5'h1d;

    // ****************************************************************
    // local interrupt status bits
    // ****************************************************************
    localparam int CIS_EV_W         = 2;
    localparam int CIS_EV_RESERVED  = 0;
    localparam int CIS_EV_BAD_WRITE = 1;

    // selector field of maskable input n (4..15)
    function automatic logic [4:0] cis_field(input logic [31:0] route_low,
                                             input logic [31:0] route_high,
                                             input int          n);
        logic [31:0] word;
        int          lsb;
        word = (n < CIS_FIRST_MASK + CIS_FIELDS) ? route_low : route_high;
        lsb  = CIS_FIELD_LSB[(n - CIS_FIRST_MASK) % CIS_FIELDS];
        return word[lsb +: CIS_SEL_W];
    endfunction : cis_field

    // true for the codes that select no source
    function automatic logic cis_reserved(input logic [4:0] code);
        logic [31:0] used;
        used = 32'h3d49_3fff;
        return !used[code];
    endfunction : cis_reserved

endpackage : cis_pkg

// >>> cis_edge_sense.sv
/*
 * Edge detector for one external interrupt pin with selectable polarity.
 * Assumes the pin is already synchronous to clk_sys.
 */
`timescale 1ns/100ps
module cis_edge_sense (
    // clock and reset
    input  wire logic clk_sys,
    input  wire logic srst,
    // pin and polarity
    input  wire logic pin,
    input  wire logic falling,
    // event
    output logic      event_pulse
);

    logic pin_q;
    logic rise;
    logic fall;

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            pin_q <= 1'b0;
        end else begin
            pin_q <= pin;
        end
    end

    assign rise        = pin & ~pin_q;
    assign fall        = ~pin & pin_q;
    // polarity picks which edge counts [R13]
    assign event_pulse = falling ? fall : rise;

endmodule : cis_edge_sense

// >>> cis_selector.sv
/*
 * CPU interrupt selector: events and pins onto sixteen CPU inputs.
 * Assumes an Avalon-MM master on clk_sys and synchronous event inputs.
 */
// Contract
// (R1) sixteen CPU inputs, input 0 highest priority
// (R2) inputs 0-3 fixed: reset, nmi, two unused
// (R3) inputs 4-15 routed by own selector field
// (R4) low register fields for inputs 4-9
// (R5) high register fields for inputs 10-15
// (R6) reset codes of inputs 4-9
// (R7) reset codes of inputs 10-15
// (R8) codes for pin and gpio sources
// (R9) codes for dma and debug events
// (R10) codes for host port, refresh, timers
// (R11) codes for serial, two-wire, net, video, audio
// (R12) software never writes reserved codes
// (R13) polarity register picks pin edge sense
// (R14) bits 15 and 31 read zero
`timescale 1ns/100ps
module cis_selector (
    // clock and reset
    input  wire logic                  clk_sys,
    input  wire logic                  srst,
    // avalon-mm slave
    input  wire logic [cis_pkg::CIS_AW-1:0] avs_address,
    input  wire logic                  avs_read,
    input  wire logic                  avs_write,
    input  wire logic [31:0]           avs_writedata,
    input  wire logic [3:0]            avs_byteenable,
    output logic [31:0]                avs_readdata,
    output logic                       avs_waitrequest,
    // fixed sources
    input  wire logic                  cpu_reset_req,
    input  wire logic                  nmi_req,
    // external pins 4..7 and gpio
    input  wire logic [3:0]            ext_pin_irq,
    input  wire logic [3:0]            gpio_pin_irq,
    input  wire logic                  gpio_pin0_irq,
    // peripheral events
    input  wire logic                  host_port_irq,
    input  wire logic                  timer_zero_irq,
    input  wire logic                  timer_one_irq,
    input  wire logic                  timer_two_irq,
    input  wire logic                  refresh_timer_irq,
    input  wire logic                  dma_ctrl_irq,
    input  wire logic                  debug_dma_event,
    input  wire logic                  debug_xchg_rx_event,
    input  wire logic                  debug_xchg_tx_event,
    input  wire logic                  sync_serial_tx_irq,
    input  wire logic                  sync_serial_rx_irq,
    input  wire logic                  two_wire_bus_irq,
    input  wire logic                  network_mgmt_irq,
    input  wire logic                  video_port_one_irq,
    input  wire logic                  video_port_two_irq,
    input  wire logic                  audio_serial_tx_irq,
    input  wire logic                  audio_serial_rx_irq,
    // cpu side
    output logic [15:0]                cpu_int,
    output logic                       irq
);
    import cis_pkg::*;

    typedef enum logic [2:0] {
        CIS_IDLE = 3'b001,
        CIS_ACK  = 3'b010,
        CIS_DONE = 3'b100
    } cis_state_t;

    // ****************************************************************
    // registers and state
    // ****************************************************************
    cis_state_t          state;
    cis_state_t          next_state;
    logic [31:0]         irq_route_low;
    logic [31:0]         irq_route_high;
    logic [31:0]         ext_pin_irq_polarity;
    logic [CIS_EV_W-1:0] irq_status;
    logic [CIS_EV_W-1:0] irq_enable;
    logic [31:0]         readdata;

    // ****************************************************************
    // bus decode
    // ****************************************************************
    wire logic        req        = avs_read | avs_write;
    wire logic        take       = (state == CIS_ACK);
    wire logic        wr_take    = take & avs_write;
    wire logic        hit_high   = (avs_address == CIS_ROUTE_HIGH);
    wire logic        hit_low    = (avs_address == CIS_ROUTE_LOW);
    wire logic        hit_pol    = (avs_address == CIS_EXT_POLARITY);
    wire logic        hit_stat   = (avs_address == CIS_IRQ_STATUS);
    wire logic        hit_clr    = (avs_address == CIS_IRQ_CLEAR);
    wire logic        hit_en     = (avs_address == CIS_IRQ_ENABLE);
    wire logic        hit_out    = (avs_address == CIS_ROUTE_OUT);
    wire logic [31:0] be_mask    = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                                    {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
    wire logic [31:0] merge_high = (irq_route_high & ~be_mask) | (avs_writedata & be_mask);
    wire logic [31:0] merge_low  = (irq_route_low & ~be_mask) | (avs_writedata & be_mask);
    wire logic [31:0] merge_pol  = (ext_pin_irq_polarity & ~be_mask) | (avs_writedata & be_mask);

    // reserved code written into any field of a route word
    function automatic logic cis_any_reserved(input logic [31:0] word);
        logic bad;
        bad = 1'b0;
        for (int f = 0; f < CIS_FIELDS; f++) begin
            bad |= cis_reserved(word[CIS_FIELD_LSB[f] +: CIS_SEL_W]);
        end
        return bad;
    endfunction : cis_any_reserved

    // software is trusted not to do this; we only flag it [R12]
    wire logic bad_write = wr_take & ((hit_high & cis_any_reserved(merge_high & CIS_ROUTE_MASK)) |
                                      (hit_low & cis_any_reserved(merge_low & CIS_ROUTE_MASK)));

    // ****************************************************************
    // bus handshake: one wait cycle for timing, answer on the second
    // ****************************************************************
    always_comb begin
        next_state = state;
        unique case (state)
            CIS_IDLE: begin
                if (req) begin
                    next_state = CIS_ACK;
                end
            end
            CIS_ACK: begin
                next_state = CIS_DONE;
            end
            CIS_DONE: begin
                next_state = CIS_IDLE;
            end
        endcase
    end

    assign avs_waitrequest = ~take;

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            state <= CIS_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // ****************************************************************
    // register writes
    // ****************************************************************
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            irq_route_low        <= CIS_ROUTE_LOW_RST; // [R6]
            irq_route_high       <= CIS_ROUTE_HIGH_RST; // [R7]
            ext_pin_irq_polarity <= CIS_POL_RST;
            irq_enable           <= '0;
        end else if (wr_take) begin
            // unused bits stay zero [R14]
            if (hit_high) irq_route_high <= merge_high & CIS_ROUTE_MASK; // [R5]
            if (hit_low) irq_route_low <= merge_low & CIS_ROUTE_MASK; // [R4]
            if (hit_pol) ext_pin_irq_polarity <= merge_pol & CIS_POL_MASK; // [R13]
            if (hit_en & avs_byteenable[0]) irq_enable <= avs_writedata[CIS_EV_W-1:0];
        end
    end

    // ****************************************************************
    // source table and routing
    // ****************************************************************
    logic [3:0]              pin_event;
    logic [CIS_NUM_SRC-1:0]  src;
    logic [15:0]             next_int;

    for (genvar p = 0; p < CIS_NUM_EXT; p++) begin : g_pin
        cis_edge_sense u_edge (
            .clk_sys     (clk_sys),
            .srst        (srst),
            .pin         (ext_pin_irq[p]),
            .falling     (ext_pin_irq_polarity[p]),
            .event_pulse (pin_event[p])
        );
    end

    always_comb begin
        src                   = '0;
        src[CIS_SRC_HOST_PORT] = host_port_irq; // [R10]
        src[CIS_SRC_TIMER0]   = timer_zero_irq;
        src[CIS_SRC_TIMER1]   = timer_one_irq;
        src[CIS_SRC_TIMER2]   = timer_two_irq;
        src[CIS_SRC_REFRESH]  = refresh_timer_irq;
        for (int p = 0; p < CIS_NUM_EXT; p++) begin
            // gpio and pin share a code [R8]
            src[CIS_SRC_PIN4 + 5'(p)] = gpio_pin_irq[p] | pin_event[p];
        end
        src[CIS_SRC_GPIO0]    = gpio_pin0_irq;
        src[CIS_SRC_DMA]      = dma_ctrl_irq; // [R9]
        src[CIS_SRC_DBG_DMA]  = debug_dma_event;
        src[CIS_SRC_DBG_RX]   = debug_xchg_rx_event;
        src[CIS_SRC_DBG_TX]   = debug_xchg_tx_event;
        src[CIS_SRC_SSP_TX]   = sync_serial_tx_irq; // [R11]
        src[CIS_SRC_SSP_RX]   = sync_serial_rx_irq;
        src[CIS_SRC_TWO_WIRE] = two_wire_bus_irq;
        src[CIS_SRC_NET_MGMT] = network_mgmt_irq;
        src[CIS_SRC_VIDEO1]   = video_port_one_irq;
        src[CIS_SRC_VIDEO2]   = video_port_two_irq;
        src[CIS_SRC_AUDIO_TX] = audio_serial_tx_irq;
        src[CIS_SRC_AUDIO_RX] = audio_serial_rx_irq;
    end

    // bit index is priority, 0 highest; the cpu arbitrates [R1]
    always_comb begin
        next_int    = '0;
        next_int[0] = cpu_reset_req; // [R2]
        next_int[1] = nmi_req;
        for (int n = CIS_FIRST_MASK; n < CIS_NUM_INT; n++) begin
            next_int[n] = src[cis_field(irq_route_low, irq_route_high, n)]; // [R3]
        end
    end

    // registered so routing changes never glitch a cpu input
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            cpu_int <= '0;
        end else begin
            cpu_int <= next_int;
        end
    end

    // ****************************************************************
    // local interrupt: reserved route seen, reserved-code write
    // ****************************************************************
    logic [CIS_EV_W-1:0] ev_set;
    logic [CIS_EV_W-1:0] ev_clr;
    logic                route_reserved;

    always_comb begin
        route_reserved = 1'b0;
        for (int n = CIS_FIRST_MASK; n < CIS_NUM_INT; n++) begin
            route_reserved |= cis_reserved(cis_field(irq_route_low, irq_route_high, n));
        end
    end

    assign ev_set = {bad_write, route_reserved};
    assign ev_clr = (wr_take & hit_clr & avs_byteenable[0]) ? avs_writedata[CIS_EV_W-1:0] : '0;

    // set beats a clear in the same cycle
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            irq_status <= '0;
        end else begin
            irq_status <= (irq_status & ~ev_clr) | ev_set;
        end
    end

    assign irq = |(irq_status & irq_enable);

    // ****************************************************************
    // read data
    // ****************************************************************
    wire logic [31:0] rd_mux =
        hit_high ? irq_route_high :
        hit_low  ? irq_route_low :
        hit_pol  ? ext_pin_irq_polarity :
        hit_stat ? {{(32-CIS_EV_W){1'b0}}, irq_status} :
        hit_en   ? {{(32-CIS_EV_W){1'b0}}, irq_enable} :
        hit_out  ? {16'h0000, cpu_int} :
                   CIS_UNMAPPED_DATA;

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            readdata <= '0;
        end else if (state == CIS_IDLE && avs_read) begin
            readdata <= rd_mux;
        end
    end

    assign avs_readdata = readdata;

    // ****************************************************************
    // checks
    // ****************************************************************
    sequence s_req_start;
        (state == CIS_IDLE) && req;
    endsequence

    sequence s_answer;
        ##1 !avs_waitrequest;
    endsequence

    bus_answer_a: assert property (@(posedge clk_sys) disable iff (srst)
        s_req_start |-> s_answer)
        else $error("bus answer not one cycle after request");

    route_pad_a: assert property (@(posedge clk_sys) disable iff (srst) // [R14]
        irq_route_low[15] == 1'b0 && irq_route_low[31] == 1'b0 &&
        irq_route_high[15] == 1'b0 && irq_route_high[31] == 1'b0)
        else $error("route pad bit set");

    fixed_inputs_a: assert property (@(posedge clk_sys) disable iff (srst) // [R2]
        ##1 cpu_int[0] == $past(cpu_reset_req) && cpu_int[1] == $past(nmi_req) && cpu_int[3:2] == 2'b00)
        else $error("fixed cpu input wrong");

    reset_low_a: assert property (@(posedge clk_sys) // [R6]
        srst |=> irq_route_low == CIS_ROUTE_LOW_RST)
        else $error("low route reset value wrong");

    reset_high_a: assert property (@(posedge clk_sys) // [R7]
        srst |=> irq_route_high == CIS_ROUTE_HIGH_RST)
        else $error("high route reset value wrong");

    low_write_a: assert property (@(posedge clk_sys) disable iff (srst) // [R4]
        (wr_take && hit_low && avs_byteenable == 4'hf) |=> irq_route_low == ($past(avs_writedata) & CIS_ROUTE_MASK))
        else $error("low route write lost");

    high_write_a: assert property (@(posedge clk_sys) disable iff (srst) // [R5]
        (wr_take && hit_high && avs_byteenable == 4'hf) |=> irq_route_high == ($past(avs_writedata) & CIS_ROUTE_MASK))
        else $error("high route write lost");

    dma_route_a: assert property (@(posedge clk_sys) disable iff (srst) // [R9]
        (irq_route_low[CIS_FIELD_LSB[4] +: CIS_SEL_W] == CIS_SRC_DMA) |=> cpu_int[8] == $past(dma_ctrl_irq))
        else $error("dma route wrong");

    timer_route_a: assert property (@(posedge clk_sys) disable iff (srst) // [R10]
        (irq_route_high[CIS_FIELD_LSB[4] +: CIS_SEL_W] == CIS_SRC_TIMER0) |=> cpu_int[14] == $past(timer_zero_irq))
        else $error("timer route wrong");

    status_sticky_a: assert property (@(posedge clk_sys) disable iff (srst)
        (irq_status[CIS_EV_BAD_WRITE] && !ev_clr[CIS_EV_BAD_WRITE]) |=> irq_status[CIS_EV_BAD_WRITE])
        else $error("status bit dropped");

endmodule : cis_selector

// >>> cis_src_model.sv
/*
 * Event sources for the interrupt selector.
 * Assumes the bench sets src_on bits by selector code.
 */
`timescale 1ns/100ps
module cis_src_model (
    // sources wanted, one bit per selector code
    input  wire logic [31:0] src_on,
    // event lines
    output logic [3:0]       gpio_pin_irq,
    output logic             gpio_pin0_irq,
    output logic             host_port_irq,
    output logic             timer_zero_irq,
    output logic             timer_one_irq,
    output logic             timer_two_irq,
    output logic             refresh_timer_irq,
    output logic             dma_ctrl_irq,
    output logic             debug_dma_event,
    output logic             debug_xchg_rx_event,
    output logic             debug_xchg_tx_event,
    output logic             sync_serial_tx_irq,
    output logic             sync_serial_rx_irq,
    output logic             two_wire_bus_irq,
    output logic             network_mgmt_irq,
    output logic             video_port_one_irq,
    output logic             video_port_two_irq,
    output logic             audio_serial_tx_irq,
    output logic             audio_serial_rx_irq
);
    // ********
    // each line follows the bit of its own code
    // ********
    assign gpio_pin_irq = src_on[7:4];
    assign gpio_pin0_irq = src_on[16];
    assign {timer_one_irq, timer_zero_irq, host_port_irq} = src_on[2:0];
    assign refresh_timer_irq = src_on[3];
    assign timer_two_irq = src_on[19];
    assign {debug_xchg_tx_event, debug_xchg_rx_event, debug_dma_event, dma_ctrl_irq} = src_on[11:8];
    assign {sync_serial_rx_irq, sync_serial_tx_irq} = src_on[13:12];
    assign two_wire_bus_irq = src_on[22];
    assign network_mgmt_irq = src_on[24];
    assign {video_port_two_irq, video_port_one_irq} = src_on[27:26];
    assign {audio_serial_rx_irq, audio_serial_tx_irq} = src_on[29:28];
endmodule : cis_src_model

// >>> tb.sv
/*
 * Self-checking bench for the interrupt selector.
 * Assumes cis_src_model drives the event lines from src_on.
 */
`timescale 1ns/100ps
module tb;
    import cis_pkg::*;
    logic        clk_sys = 1'h0;
    logic        srst = 1'h1;
    logic [31:0] avs_address = '0;
    logic [31:0] avs_writedata = '0;
    logic [31:0] src_on = '0;
    logic [3:0]  avs_byteenable = 4'hf;
    logic [3:0]  ext_pin_irq = '0;
    logic        avs_read = 1'h0;
    logic        avs_write = 1'h0;
    logic        cpu_reset_req = 1'h0;
    logic        nmi_req = 1'h0;
    logic [31:0] rd;
    wire  [31:0] avs_readdata, low_def, high_def;
    wire  [15:0] cpu_int;
    wire  [3:0]  gpio_pin_irq;
    wire         avs_waitrequest, irq, gpio_pin0_irq, host_port_irq, timer_zero_irq, timer_one_irq,
                 timer_two_irq, refresh_timer_irq, dma_ctrl_irq, debug_dma_event, debug_xchg_rx_event,
                 debug_xchg_tx_event, sync_serial_tx_irq, sync_serial_rx_irq, two_wire_bus_irq,
                 network_mgmt_irq, video_port_one_irq, video_port_two_irq, audio_serial_tx_irq,
                 audio_serial_rx_irq;
    int          failures = 0;
    int          cmp_count = 0;
    // reset codes of inputs 4..15; codes that name a source
    logic [4:0]  def_code [4:15] = '{5'h04, 5'h05, 5'h06, 5'h07, 5'h08, 5'h09, 5'h03, 5'h0a, 5'h0b,
                                     5'h00, 5'h01, 5'h02};
    logic [31:0] used = 32'h3d49_3fff;
    assign low_def = {1'h0, def_code[9], def_code[8], def_code[7], 1'h0, def_code[6], def_code[5], def_code[4]};
    assign high_def = {1'h0, def_code[15], def_code[14], def_code[13], 1'h0, def_code[12], def_code[11],
                       def_code[10]};
    always #2 clk_sys = ~clk_sys;
    // ********
    // source model and design
    // ********
    cis_src_model src (.src_on, .gpio_pin_irq, .gpio_pin0_irq, .host_port_irq, .timer_zero_irq,
        .timer_one_irq, .timer_two_irq, .refresh_timer_irq, .dma_ctrl_irq, .debug_dma_event,
        .debug_xchg_rx_event, .debug_xchg_tx_event, .sync_serial_tx_irq, .sync_serial_rx_irq,
        .two_wire_bus_irq, .network_mgmt_irq, .video_port_one_irq, .video_port_two_irq,
        .audio_serial_tx_irq, .audio_serial_rx_irq);
    cis_selector dut (.clk_sys, .srst, .avs_address, .avs_read, .avs_write, .avs_writedata,
        .avs_byteenable, .avs_readdata, .avs_waitrequest, .cpu_reset_req, .nmi_req, .ext_pin_irq,
        .gpio_pin_irq, .gpio_pin0_irq, .host_port_irq, .timer_zero_irq, .timer_one_irq,
        .timer_two_irq, .refresh_timer_irq, .dma_ctrl_irq, .debug_dma_event, .debug_xchg_rx_event,
        .debug_xchg_tx_event, .sync_serial_tx_irq, .sync_serial_rx_irq, .two_wire_bus_irq,
        .network_mgmt_irq, .video_port_one_irq, .video_port_two_irq, .audio_serial_tx_irq,
        .audio_serial_rx_irq, .cpu_int, .irq);
    // ********
    // shared tasks
    // ********
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            failures++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        // iff sees the pre-edge level
        @(posedge clk_sys iff avs_waitrequest === 1'h0);
        rd = avs_readdata;
        avs_read <= 1'h0;
        avs_write <= 1'h0;
    endtask : bus
    task automatic settle(input int n);
        repeat (n) @(posedge clk_sys);
        @(negedge clk_sys);
    endtask : settle
    task automatic pulses(input logic v, input logic [31:0] exp);
        logic [31:0] n = '0;
        @(posedge clk_sys);
        ext_pin_irq[0] <= v;
        repeat (6) begin
            @(negedge clk_sys);
            n = n + (cpu_int[4] === 1'h1);
        end
        chk("pin pulses", n, exp);
    endtask : pulses
    // ********
    // scenarios
    // ********
    task automatic t_reset;
        chk("cpu_int", cpu_int, '0);
        bus(1'h0, CIS_ROUTE_LOW, '0);
        chk("route_low", rd, low_def);
        bus(1'h0, CIS_ROUTE_HIGH, '0);
        chk("route_high", rd, high_def);
        bus(1'h0, CIS_EXT_POLARITY, '0);
        chk("polarity", rd, '0);
        bus(1'h0, 32'h019c_000c, '0);
        chk("unmapped", rd, '0);
        $display("test reset done");
    endtask : t_reset
    task automatic t_fixed;
        @(posedge clk_sys);
        src_on <= 32'hffff_ffff;
        cpu_reset_req <= 1'h1;
        nmi_req <= 1'h1;
        settle(1);
        chk("all sources", cpu_int, 16'hfff3);
        bus(1'h0, CIS_ROUTE_OUT, '0);
        chk("route out", rd, 16'hfff3);
        for (int n = 4; n < 16; n++) begin
            @(posedge clk_sys);
            src_on <= 32'h1 << def_code[n];
            cpu_reset_req <= 1'h0;
            nmi_req <= 1'h0;
            settle(1);
            chk("default route", cpu_int, 32'h1 << n);
        end
        $display("test fixed done");
    endtask : t_fixed
    task automatic t_codes;
        for (int i = 0; i < 32; i++) begin
            @(posedge clk_sys);
            src_on <= '0;
            bus(1'h1, CIS_ROUTE_LOW, {low_def[31:5], 5'(i)});
            bus(1'h1, CIS_ROUTE_HIGH, {1'h0, 5'(i), high_def[25:0]});
            settle(1);
            chk("idle route", {cpu_int[15], cpu_int[4]}, '0);
            @(posedge clk_sys);
            src_on <= 32'h1 << i;
            settle(1);
            chk("code route", {cpu_int[15], cpu_int[4]}, used[i] ? 32'h3 : '0);
        end
        bus(1'h1, CIS_ROUTE_LOW, 32'hf7bd_f7bd);
        bus(1'h0, CIS_ROUTE_LOW, '0);
        chk("low spare bits", rd, 32'h77bd_77bd);
        bus(1'h1, CIS_ROUTE_HIGH, 32'hf7bd_f7bd);
        bus(1'h0, CIS_ROUTE_HIGH, '0);
        chk("high spare bits", rd, 32'h77bd_77bd);
        bus(1'h1, CIS_ROUTE_LOW, low_def);
        bus(1'h1, CIS_ROUTE_HIGH, high_def);
        $display("test codes done");
    endtask : t_codes
    task automatic t_pins;
        @(posedge clk_sys);
        src_on <= '0;
        bus(1'h1, CIS_EXT_POLARITY, 32'hffff_ffff);
        bus(1'h0, CIS_EXT_POLARITY, '0);
        chk("polarity bits", rd, 32'h0000_000f);
        bus(1'h1, CIS_EXT_POLARITY, 32'h0000_0001);
        pulses(1'h1, '0);
        pulses(1'h0, 32'h1);
        bus(1'h1, CIS_EXT_POLARITY, '0);
        pulses(1'h1, 32'h1);
        pulses(1'h0, '0);
        $display("test pins done");
    endtask : t_pins
    task automatic t_irq;
        bus(1'h1, CIS_IRQ_ENABLE, 32'h3);
        bus(1'h1, CIS_ROUTE_LOW, {low_def[31:5], 5'h12});
        settle(2);
        chk("irq raised", irq, 32'h1);
        bus(1'h0, CIS_IRQ_STATUS, '0);
        chk("status", rd, 32'h3);
        bus(1'h1, CIS_IRQ_ENABLE, '0);
        settle(1);
        chk("irq masked", irq, '0);
        bus(1'h1, CIS_ROUTE_LOW, low_def);
        bus(1'h1, CIS_IRQ_CLEAR, 32'h3);
        bus(1'h0, CIS_IRQ_STATUS, '0);
        chk("status cleared", rd, '0);
        bus(1'h1, CIS_IRQ_ENABLE, 32'h3);
        settle(1);
        chk("irq idle", irq, '0);
        $display("test irq done");
    endtask : t_irq
    task automatic tally_and_finish;
        $display("compares %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : tally_and_finish
    initial begin
        repeat (20) @(posedge clk_sys);
        srst <= 1'h0;
        t_reset;
        t_fixed;
        t_codes;
        t_pins;
        t_irq;
        tally_and_finish;
    end
    // a run takes under a thousand cycles
    initial begin
        repeat (5000) @(posedge clk_sys);
        failures++;
        tally_and_finish;
    end
endmodule : tb
